// ---- i2cbr_regs.vh ----
// register offsets, field positions, reset values and lookup widths
// for the two-wire bit-rate and own-address block
// assumes a byte-wide register port with a 4-bit address
`ifndef I2CBR_REGS_VH
`define I2CBR_REGS_VH

// register offsets
`define I2CBR_OFS_OWN_ADDR   4'h0
`define I2CBR_OFS_RATE_DIV   4'h1
`define I2CBR_OFS_CTRL       4'h2
`define I2CBR_OFS_STATUS     4'h3

// bit_rate_divider fields
`define I2CBR_MUL_HI         7
`define I2CBR_MUL_LO         6
`define I2CBR_CODE_HI        5
`define I2CBR_CODE_LO        0

// multiplier codes
`define I2CBR_MUL_X1         2'h0
`define I2CBR_MUL_X2         2'h1
`define I2CBR_MUL_X4         2'h2
`define I2CBR_MUL_RSVD       2'h3

// control register fields
`define I2CBR_CTRL_RUN       0

// status register fields
`define I2CBR_ST_RUN         0
`define I2CBR_ST_SCL         1
`define I2CBR_ST_HOLD        2
`define I2CBR_ST_MATCH       3

// reset values
`define I2CBR_RST_OWN_ADDR   8'h00
`define I2CBR_RST_RATE_DIV   8'h00
`define I2CBR_RST_CTRL       8'h00

// widths of looked-up and scaled counts
`define I2CBR_DIV_W          12
`define I2CBR_HOLD_W         10
`define I2CBR_PER_W          14
`define I2CBR_HCNT_W         12

`endif

// ---- i2cbr_rate_lut.v ----
// fixed lookup from 6-bit clock-rate code to scl divider and sda hold value
// purely combinational; the caller registers the results
`timescale 1ns/1ps
`include "i2cbr_regs.vh"

module i2cbr_rate_lut (
  // code in
  input  wire [5:0]                 clock_rate_code,
  // looked-up values
  output wire [`I2CBR_DIV_W-1:0]    scl_div,
  output wire [`I2CBR_HOLD_W-1:0]   sda_hold
);

  // first four groups of eight held as a table; higher groups scale group 3
  function [`I2CBR_DIV_W-1:0] base_div;
    input [4:0] c;
    begin
      case (c)
        5'h00: base_div = 12'h014;
        5'h01: base_div = 12'h016;
        5'h02: base_div = 12'h018;
        5'h03: base_div = 12'h01a;
        5'h04: base_div = 12'h01c;
        5'h05: base_div = 12'h01e;
        5'h06: base_div = 12'h022;
        5'h07: base_div = 12'h028;
        5'h08: base_div = 12'h01c;
        5'h09: base_div = 12'h020;
        5'h0a: base_div = 12'h024;
        5'h0b: base_div = 12'h028;
        5'h0c: base_div = 12'h02c;
        5'h0d: base_div = 12'h030;
        5'h0e: base_div = 12'h038;
        5'h0f: base_div = 12'h044;
        5'h10: base_div = 12'h030;
        5'h11: base_div = 12'h038;
        5'h12: base_div = 12'h040;
        5'h13: base_div = 12'h048;
        5'h14: base_div = 12'h050;
        5'h15: base_div = 12'h058;
        5'h16: base_div = 12'h068;
        5'h17: base_div = 12'h080;
        5'h18: base_div = 12'h050;
        5'h19: base_div = 12'h060;
        5'h1a: base_div = 12'h070;
        5'h1b: base_div = 12'h080;
        5'h1c: base_div = 12'h090;
        5'h1d: base_div = 12'h0a0;
        5'h1e: base_div = 12'h0c0;
        5'h1f: base_div = 12'h0f0;
        default: base_div = 12'h014;
      endcase
    end
  endfunction

  function [`I2CBR_HOLD_W-1:0] base_hold;
    input [4:0] c;
    begin
      case (c[4:1])
        4'h0: base_hold = 10'h007;
        4'h1: base_hold = 10'h008;
        4'h2: base_hold = 10'h009;
        4'h3: base_hold = 10'h00a;
        4'h4: base_hold = 10'h007;
        4'h5: base_hold = 10'h009;
        4'h6: base_hold = 10'h00b;
        4'h7: base_hold = 10'h00d;
        4'h8: base_hold = 10'h009;
        4'h9: base_hold = 10'h00d;
        4'ha: base_hold = 10'h011;
        4'hb: base_hold = 10'h015;
        4'hc: base_hold = 10'h009;
        4'hd: base_hold = 10'h011;
        4'he: base_hold = 10'h019;
        4'hf: base_hold = 10'h021;
        default: base_hold = 10'h007;
      endcase
    end
  endfunction

  wire [4:0]                 low_code = {2'h3, clock_rate_code[2:0]};
  wire [1:0]                 up_shift = clock_rate_code[4:3];
  // three bits wide so the top group shifts by four instead of wrapping to zero
  wire [2:0]                 grp_shift = {1'b0, up_shift} + 3'h1;
  wire [`I2CBR_DIV_W-1:0]    g3_div   = base_div(low_code);
  wire [`I2CBR_HOLD_W-1:0]   g3_hold  = base_hold(low_code);
  wire [`I2CBR_HOLD_W-1:0]   g3_hm1   = g3_hold - 10'h001;

  // groups 4..7: divider doubles per group, hold follows (h-1)*2^n+1
  assign scl_div  = clock_rate_code[5]
                    ? (g3_div << grp_shift)
                    : base_div(clock_rate_code[4:0]);
  assign sda_hold = clock_rate_code[5]
                    ? ((g3_hm1 << grp_shift) + 10'h001)
                    : base_hold(clock_rate_code[4:0]);

endmodule // i2cbr_rate_lut

// ---- i2cbr_core.v ----
// bit-rate generator, sda hold timer and own-address match
// for a two-wire serial bus interface
// assumes a single-cycle register port and a protocol engine that
// requests clocking through scl_run and presents calling addresses
`timescale 1ns/1ps
`include "i2cbr_regs.vh"

module i2cbr_core (
  // clock and reset
  input  wire        ref_clk,
  input  wire        sys_rst,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // protocol engine side
  input  wire        scl_run,
  input  wire [6:0]  call_addr,
  input  wire        call_valid,
  output reg         addr_match,
  output reg         scl_level,
  output reg         scl_fall,
  output reg         bit_start,
  output reg         sda_update
);

  localparam ST_IDLE = 2'h0;
  localparam ST_HIGH = 2'h1;
  localparam ST_LOW  = 2'h2;

  // software-visible registers
  reg  [7:0]                own_slave_address_reg;
  reg  [7:0]                bit_rate_divider_reg;
  reg  [7:0]                ctrl_reg;

  // timing state
  reg  [1:0]                state_reg;
  reg  [1:0]                state_next;
  reg  [`I2CBR_PER_W-1:0]   half_reg;
  reg  [`I2CBR_PER_W-1:0]   cnt_reg;
  reg  [`I2CBR_HCNT_W-1:0]  hold_len_reg;
  reg  [`I2CBR_HCNT_W-1:0]  hold_cnt_reg;
  reg                       hold_busy_reg;

  wire [1:0]                rate_multiplier_select;
  wire [5:0]                clock_rate_code;
  wire [`I2CBR_DIV_W-1:0]   scl_div;
  wire [`I2CBR_HOLD_W-1:0]  sda_hold;
  reg  [1:0]                mul_shift;
  wire [`I2CBR_PER_W-1:0]   period_cycles;
  wire [`I2CBR_HCNT_W-1:0]  hold_cycles;
  wire                      run_req;
  wire                      cnt_done;
  wire                      hold_done;

  assign rate_multiplier_select = bit_rate_divider_reg[`I2CBR_MUL_HI:`I2CBR_MUL_LO];
  assign clock_rate_code        = bit_rate_divider_reg[`I2CBR_CODE_HI:`I2CBR_CODE_LO];
  assign run_req                = scl_run & ctrl_reg[`I2CBR_CTRL_RUN];

  i2cbr_rate_lut u_lut (
    .clock_rate_code (clock_rate_code),
    .scl_div         (scl_div),
    .sda_hold        (sda_hold)
  );

  // reserved multiplier code falls back to x1 rather than an odd factor
  always @*
  begin
    case (rate_multiplier_select)
      `I2CBR_MUL_X1: mul_shift = 2'h0;
      `I2CBR_MUL_X2: mul_shift = 2'h1;
      `I2CBR_MUL_X4: mul_shift = 2'h2;
      default:       mul_shift = 2'h0;
    endcase
  end

  // full bit period and hold delay in clock cycles
  assign period_cycles = {2'h0, scl_div} << mul_shift;
  assign hold_cycles   = {2'h0, sda_hold} << mul_shift;

  // register writes
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      own_slave_address_reg <= `I2CBR_RST_OWN_ADDR;
      bit_rate_divider_reg  <= `I2CBR_RST_RATE_DIV;
      ctrl_reg              <= `I2CBR_RST_CTRL;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `I2CBR_OFS_OWN_ADDR: own_slave_address_reg <= reg_wdata;
        `I2CBR_OFS_RATE_DIV: bit_rate_divider_reg  <= reg_wdata;
        `I2CBR_OFS_CTRL:     ctrl_reg <= {7'h00, reg_wdata[`I2CBR_CTRL_RUN]};
        default:             ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads return zero
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `I2CBR_OFS_OWN_ADDR: reg_rdata <= own_slave_address_reg;
        `I2CBR_OFS_RATE_DIV: reg_rdata <= bit_rate_divider_reg;
        `I2CBR_OFS_CTRL:     reg_rdata <= ctrl_reg;
        `I2CBR_OFS_STATUS:   reg_rdata <= {4'h0, addr_match, hold_busy_reg,
                                           scl_level, (state_reg != ST_IDLE)};
        default:             reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // 7-bit calling address compared against the upper seven bits
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      addr_match <= 1'b0;
    else
      addr_match <= call_valid & (call_addr == own_slave_address_reg[7:1]);
  end

  assign cnt_done = (cnt_reg == {`I2CBR_PER_W{1'b0}});

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (run_req) state_next = ST_HIGH;
      ST_HIGH: if (cnt_done) state_next = ST_LOW;
      ST_LOW:  if (cnt_done) state_next = run_req ? ST_HIGH : ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // scl half-period counter; settings are sampled only at a bit start so a
  // mid-bit write cannot stretch or chop the current bit
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_reg    <= ST_IDLE;
      half_reg     <= {`I2CBR_PER_W{1'b0}};
      cnt_reg      <= {`I2CBR_PER_W{1'b0}};
      hold_len_reg <= {`I2CBR_HCNT_W{1'b0}};
      scl_level    <= 1'b1;
      scl_fall     <= 1'b0;
      bit_start    <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      scl_fall  <= 1'b0;
      bit_start <= 1'b0;
      if (state_next == ST_HIGH && state_reg != ST_HIGH)
      begin
        half_reg     <= period_cycles >> 1;
        cnt_reg      <= (period_cycles >> 1) - 14'h0001;
        hold_len_reg <= hold_cycles;
        scl_level    <= 1'b1;
        bit_start    <= 1'b1;
      end
      else if (state_next == ST_LOW && state_reg == ST_HIGH)
      begin
        cnt_reg   <= half_reg - 14'h0001;
        scl_level <= 1'b0;
        scl_fall  <= 1'b1;
      end
      else if (state_next == ST_IDLE)
      begin
        cnt_reg   <= {`I2CBR_PER_W{1'b0}};
        scl_level <= 1'b1;
      end
      else
        cnt_reg <= cnt_reg - 14'h0001;
    end
  end

  assign hold_done = hold_busy_reg & (hold_cnt_reg == {`I2CBR_HCNT_W{1'b0}});

  // sda hold timer, started on each scl fall, pulses when sda may change
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      hold_busy_reg <= 1'b0;
      hold_cnt_reg  <= {`I2CBR_HCNT_W{1'b0}};
      sda_update    <= 1'b0;
    end
    else
    begin
      sda_update <= hold_done;
      if (state_next == ST_LOW && state_reg == ST_HIGH)
      begin
        hold_busy_reg <= 1'b1;
        // pulse lands exactly hold_len cycles after the fall pulse
        hold_cnt_reg  <= hold_len_reg - 12'h001;
      end
      else if (hold_done)
        hold_busy_reg <= 1'b0;
      else if (hold_busy_reg)
        hold_cnt_reg <= hold_cnt_reg - 12'h001;
    end
  end

endmodule // i2cbr_core

// ---- i2cbr_monitor.sv ----
// checker for the bit-rate and own-address core
// sees only the core ports; attached by the bind at the foot
`timescale 1ns/1ps
module i2cbr_monitor (
  // clock and reset
  input logic       ref_clk,
  input logic       sys_rst,
  // register port
  input logic [3:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic [7:0] reg_rdata,
  // engine side
  input logic       scl_run,
  input logic [6:0] call_addr,
  input logic       call_valid,
  input logic       addr_match,
  input logic       scl_level,
  input logic       scl_fall,
  input logic       bit_start,
  input logic       sda_update
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] own_sh;
  logic [7:0] rate_sh;
  // shadows of the own-address and rate software registers
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      own_sh  <= 8'h00;
      rate_sh <= 8'h00;
    end
    else if (reg_wr && reg_addr == 4'h0)
      own_sh <= reg_wdata;
    else if (reg_wr && reg_addr == 4'h1)
      rate_sh <= reg_wdata;
  end
  sequence s_high8; scl_level [*8]; endsequence
  sequence s_low8; !scl_level [*8]; endsequence
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_own_back: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata == own_sh)
    else $error("own address readback wrong");
  a_rate_back: assert property (reg_rd && reg_addr == 4'h1 |=> reg_rdata == rate_sh)
    else $error("rate register readback wrong");
  a_match_hit: assert property (call_valid && call_addr == own_sh[7:1] |=> addr_match)
    else $error("equal calling address not matched");
  a_match_miss: assert property (!(call_valid && call_addr == own_sh[7:1]) |=> !addr_match)
    else $error("match without equal calling address");
  a_fall_edge: assert property (scl_fall |-> $fell(scl_level))
    else $error("fall pulse without clock falling");
  a_high_min: assert property (bit_start |-> s_high8)
    else $error("high phase too short");
  a_low_min: assert property (scl_fall |-> s_low8)
    else $error("low phase too short");
  a_hold_min: assert property (scl_fall |=> !sda_update [*6])
    else $error("data change before shortest hold");
endmodule // i2cbr_monitor

bind i2cbr_core i2cbr_monitor u_mon (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .scl_run, .call_addr, .call_valid, .addr_match, .scl_level,
  .scl_fall, .bit_start, .sda_update);

// ---- i2cbr_caller.sv ----
// caller model: presents one calling address per bench request
// assumes one-cycle requests from the bench
`timescale 1ns/1ps
module i2cbr_caller (
  // clock and reset
  input logic        ref_clk,
  input logic        sys_rst,
  // bench request
  input logic        req,
  input logic [6:0]  req_addr,
  // toward the core
  output logic [6:0] call_addr,
  output logic       call_valid
);
  always_ff @(posedge ref_clk)
  begin
    call_valid <= req & ~sys_rst;
    // released address is scrambled so a stale value cannot pass for a match
    call_addr  <= (req || sys_rst) ? req_addr : ~call_addr;
  end
endmodule // i2cbr_caller

// ---- i2c_bit_rate_and_own_address_tb.sv ----
// self-checking bench for the bit-rate and own-address core
// assumes the core register map and the caller model beside it
`timescale 1ns/1ps
`include "i2cbr_regs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module i2c_bit_rate_and_own_address_tb;
  logic       ref_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       scl_run = 1'b0;
  logic       req = 1'b0;
  logic [6:0] req_addr = 7'h00;
  wire  [7:0] reg_rdata;
  wire  [6:0] call_addr;
  wire        call_valid, addr_match, scl_level, scl_fall, bit_start, sda_update;
  int         err_total = 0;
  int         total_checks = 0;
  // divider for codes 00-27, hold for code pairs 00-27; later groups double the divider and take 2h-1 for hold
  int dtab [40] = '{20,22,24,26,28,30,34,40,28,32,36,40,44,48,56,68,48,56,64,72,80,88,
    104,128,80,96,112,128,144,160,192,240,160,192,224,256,288,320,384,480};
  int htab [20] = '{7,8,9,10,7,9,11,13,9,13,17,21,9,17,25,33,17,33,49,65};

  i2cbr_core u_dut (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .scl_run, .call_addr, .call_valid, .addr_match, .scl_level, .scl_fall,
    .bit_start, .sda_update);
  i2cbr_caller u_caller (.ref_clk, .sys_rst, .req, .req_addr, .call_addr, .call_valid);

  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end

  function automatic int div_f(input int c);
    return c < 40 ? dtab[c] : 2 * div_f(c - 8);
  endfunction
  function automatic int hold_f(input int c);
    return c < 40 ? htab[c / 2] : 2 * hold_f(c - 8) - 1;
  endfunction

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic call(input logic [6:0] a, input logic e);
    @(posedge ref_clk);
    req      <= 1'b1;
    req_addr <= a;
    @(posedge ref_clk);
    req      <= 1'b0;
    @(posedge ref_clk);
    #1 `CHK(addr_match, e)
  endtask
  task automatic wb;
    int k;
    for (k = 0; k < 20000 && bit_start !== 1'b1; k++)
      @(posedge ref_clk) #1;
    if (k >= 20000)
    begin
      err_total++;
      summarize;
    end
  endtask
  // the first bit after a write may still carry the old settings
  task automatic meas(input logic [1:0] m, input logic [5:0] c);
    int p, h, n, tf, tu, sh;
    sh = (m == 2'h1) ? 1 : (m == 2'h2) ? 2 : 0;
    p = div_f(c) << sh;
    h = hold_f(c) << sh;
    wr(`I2CBR_OFS_RATE_DIV, {m, c});
    #1 wb;
    @(posedge ref_clk);
    #1 wb;
    n = 0;
    tf = 0;
    tu = 0;
    do
    begin
      @(posedge ref_clk);
      #1 n++;
      if (scl_fall === 1'b1) tf = n;
      if (sda_update === 1'b1) tu = n;
    end while (bit_start !== 1'b1 && n < 20000);
    `CHK(n, p)
    `CHK(tf, p / 2)
    `CHK(tu, p / 2 + h)
    if (n >= 20000)
    begin
      err_total++;
      summarize;
    end
    $display("test timing code %h mul %h done", c, m);
  endtask

  initial
  begin
    logic [7:0] d;
    logic [7:0] v;
    int i;
    i = $urandom(32'hc25a);
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    wr(4'h7, 8'hff);
    for (i = 0; i < 8; i++)
    begin
      rd(4'(i), d);
      `CHK(d, (i == 3) ? 8'h02 : 8'h00)
    end
    $display("test reset values done");
    for (i = 0; i < 6; i++)
    begin
      v = 8'($urandom);
      wr(`I2CBR_OFS_OWN_ADDR, v);
      rd(`I2CBR_OFS_OWN_ADDR, d);
      `CHK(d, v)
      call(v[7:1], 1'b1);
      call(v[7:1] ^ (7'h01 << (i % 7)), 1'b0);
    end
    $display("test own address done");
    for (i = 0; i < 256; i++)
    begin
      wr(`I2CBR_OFS_RATE_DIV, 8'(i));
      rd(`I2CBR_OFS_RATE_DIV, d);
      `CHK(d, 8'(i))
    end
    $display("test rate readback done");
    @(posedge ref_clk);
    scl_run <= 1'b1;
    wr(`I2CBR_OFS_CTRL, 8'hff);
    rd(`I2CBR_OFS_CTRL, d);
    `CHK(d, 8'h01)
    meas(2'h0, 6'h00);
    meas(2'h0, 6'h3f);
    meas(2'h0, 6'h38);
    meas(2'h1, 6'h0b);
    meas(2'h3, 6'h0b);
    for (i = 0; i < 8; i++)
      meas(2'($urandom % 3), 6'($urandom % 40));
    summarize;
  end
endmodule // i2c_bit_rate_and_own_address_tb
